// File: logic/ccie_pkg.sv
// constants and types shared by the clock controller interrupt enable block
package ccie_pkg;

  // bus and source widths
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int NUM_SRC = 12;

  // register byte offsets
  localparam logic [7:0] OFS_EN_CLR = 8'h00;
  localparam logic [7:0] OFS_EN_SET = 8'h04;
  localparam logic [7:0] OFS_FLAG   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_WPROT  = 8'h10;

  // reset values
  localparam logic [31:0] SET_REG_RESET = 32'h0000_0000;
  localparam logic [11:0] EN_RESET      = 12'h000;
  localparam logic [11:0] FLAG_RESET    = 12'h000;
  localparam logic        WPROT_RESET   = 1'b0;

  // source bit positions, shared by enable, flag and status registers
  localparam int BIT_CRYSTAL_MAIN_READY    = 0;
  localparam int BIT_CRYSTAL_32K_READY     = 1;
  localparam int BIT_RC_32K_READY          = 2;
  localparam int BIT_RC_8MHZ_READY         = 3;
  localparam int BIT_LOOP_READY            = 4;
  localparam int BIT_LOOP_OUT_OF_BOUNDS    = 5;
  localparam int BIT_LOOP_FINE_LOCK        = 6;
  localparam int BIT_LOOP_COARSE_LOCK      = 7;
  localparam int BIT_LOOP_REF_CLOCK_STOPPED = 8;
  localparam int BIT_SUPPLY_MON_READY      = 9;
  localparam int BIT_SUPPLY_MON_DETECT     = 10;
  localparam int BIT_SUPPLY_MON_SYNC_READY = 11;

  // write-protect register field
  localparam int WPROT_LOCK_BIT = 0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bus channel states
  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP    = 1'b1
  } ccie_wr_state_t;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } ccie_rd_state_t;

endpackage

// File: logic/ccie_status_sync.sv
// three-stage synchroniser and rising-edge detector for status levels
`timescale 1ns/100ps
module ccie_status_sync #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // asynchronous status levels
  input  wire logic [W-1:0] i_level,
  // filtered level and one-cycle rise pulse
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_a_reg;
  logic [W-1:0] sync_b_reg;
  logic [W-1:0] stable_reg;
  logic [W-1:0] stable_next;
  logic [W-1:0] rise_reg;

  // synchroniser chain; first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg   <= '0;
      sync_a_reg <= '0;
      sync_b_reg <= '0;
    end else begin
      meta_reg   <= i_level;
      sync_a_reg <= meta_reg;
      sync_b_reg <= sync_a_reg;
    end
  end

  // accept a change only once stages two and three agree
  assign stable_next = ((sync_a_reg ~^ sync_b_reg) & sync_b_reg)
                     | ((sync_a_reg ^ sync_b_reg) & stable_reg);

  // stable level and zero-to-one detection
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stable_reg <= '0;
      rise_reg   <= '0;
    end else begin
      stable_reg <= stable_next;
      rise_reg   <= stable_next & ~stable_reg;
    end
  end

  assign o_level = stable_reg;
  assign o_rise  = rise_reg;

endmodule // ccie_status_sync

// File: logic/ccie_irq_flags.sv
// sticky interrupt flags with write-one-to-clear and enable gating
`timescale 1ns/100ps
module ccie_irq_flags #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // flag set and clear
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clear,
  // enables
  input  wire logic [W-1:0] i_enable,
  // flags and combined request
  output logic      [W-1:0] o_flag,
  output logic              o_irq
);

  logic [W-1:0] flag_reg;
  logic [W-1:0] flag_next;
  logic         irq_reg;

  // a rise in the same cycle as a clear keeps the flag set
  assign flag_next = (flag_reg & ~i_clear) | i_set;

  // flag storage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_reg <= ccie_pkg::FLAG_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // request is the or of every enabled flag
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flag_reg & i_enable);
    end
  end

  assign o_flag = flag_reg;
  assign o_irq  = irq_reg;

endmodule // ccie_irq_flags

// File: logic/ccie_top.sv
// clock controller interrupt enable block with axi4-lite register slave
`timescale 1ns/100ps
module ccie_top #(
  parameter int NUM_SRC = ccie_pkg::NUM_SRC
) (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // axi4-lite write address
  input  wire logic                          i_awvalid,
  input  wire logic [ccie_pkg::ADDR_W-1:0]   i_awaddr,
  input  wire logic [2:0]                    i_awprot,
  output logic                               o_awready,
  // axi4-lite write data
  input  wire logic                          i_wvalid,
  input  wire logic [ccie_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic [ccie_pkg::DATA_W/8-1:0] i_wstrb,
  output logic                               o_wready,
  // axi4-lite write response
  output logic                               o_bvalid,
  output logic [1:0]                         o_bresp,
  input  wire logic                          i_bready,
  // axi4-lite read address
  input  wire logic                          i_arvalid,
  input  wire logic [ccie_pkg::ADDR_W-1:0]   i_araddr,
  input  wire logic [2:0]                    i_arprot,
  output logic                               o_arready,
  // axi4-lite read data
  output logic                               o_rvalid,
  output logic [ccie_pkg::DATA_W-1:0]        o_rdata,
  output logic [1:0]                         o_rresp,
  input  wire logic                          i_rready,
  // status levels from oscillators, loop and supply monitor
  input  wire logic [NUM_SRC-1:0]            i_clock_status,
  // interrupt request and current enables
  output logic                               o_irq,
  output logic [NUM_SRC-1:0]                 o_irq_enable
);

  // word-address match of a bus address against a register offset
  function automatic logic addr_hit(input logic [ccie_pkg::ADDR_W-1:0] addr,
                                    input logic [7:0] ofs);
    addr_hit = (addr[ccie_pkg::ADDR_W-1:2] == ofs[ccie_pkg::ADDR_W-1:2]);
  endfunction

  // expand byte strobes into a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    strb_mask = m;
  endfunction

  // write channel state
  ccie_pkg::ccie_wr_state_t          wr_state_reg;
  logic                              aw_got_reg;
  logic                              w_got_reg;
  logic [ccie_pkg::ADDR_W-1:0]       awaddr_reg;
  logic [ccie_pkg::DATA_W-1:0]       wdata_reg;
  logic [ccie_pkg::DATA_W/8-1:0]     wstrb_reg;
  logic [1:0]                        bresp_reg;
  logic                              aw_fire;
  logic                              w_fire;
  logic                              wr_commit;

  // read channel state
  ccie_pkg::ccie_rd_state_t          rd_state_reg;
  logic [ccie_pkg::DATA_W-1:0]       rdata_reg;
  logic [1:0]                        rresp_reg;
  logic                              ar_fire;

  // register contents and decode
  logic [NUM_SRC-1:0]                enable_reg;
  logic                              lock_reg;
  logic [ccie_pkg::DATA_W-1:0]       wdata_m;
  logic [NUM_SRC-1:0]                write_bits;
  logic                              hit_set;
  logic                              hit_clr;
  logic                              hit_flag;
  logic                              hit_status;
  logic                              hit_wprot;
  logic                              wr_mapped;
  logic                              wr_blocked;

  // source status and flags
  logic [NUM_SRC-1:0]                status_level;
  logic [NUM_SRC-1:0]                status_rise;
  logic [NUM_SRC-1:0]                flag_clear;
  logic [NUM_SRC-1:0]                flag_value;
  logic [ccie_pkg::DATA_W-1:0]       rd_word;
  logic [1:0]                        rd_resp;

  // ------------------------------------------------------------------
  // write address and data are taken in either order
  assign o_awready = (wr_state_reg == ccie_pkg::WR_COLLECT) & ~aw_got_reg;
  assign o_wready  = (wr_state_reg == ccie_pkg::WR_COLLECT) & ~w_got_reg;
  assign aw_fire   = i_awvalid & o_awready;
  assign w_fire    = i_wvalid & o_wready;
  assign wr_commit = (wr_state_reg == ccie_pkg::WR_COLLECT) & aw_got_reg & w_got_reg;

  // capture write address
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_got_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (wr_commit) begin
      aw_got_reg <= 1'b0;
    end else if (aw_fire) begin
      aw_got_reg <= 1'b1;
      awaddr_reg <= i_awaddr;
    end
  end

  // capture write data and strobes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      w_got_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (wr_commit) begin
      w_got_reg <= 1'b0;
    end else if (w_fire) begin
      w_got_reg <= 1'b1;
      wdata_reg <= i_wdata;
      wstrb_reg <= i_wstrb;
    end
  end

  // write response sequencing
  // bresp is decided at the commit edge and stands until bready
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_state_reg <= ccie_pkg::WR_COLLECT;
      bresp_reg    <= ccie_pkg::RESP_OKAY;
    end else begin
      case (wr_state_reg)
        ccie_pkg::WR_COLLECT: begin
          if (wr_commit) begin
            wr_state_reg <= ccie_pkg::WR_RESP;
            bresp_reg    <= (wr_mapped & ~wr_blocked) ? ccie_pkg::RESP_OKAY
                                                      : ccie_pkg::RESP_SLVERR;
          end
        end
        ccie_pkg::WR_RESP: begin
          if (i_bready) begin
            wr_state_reg <= ccie_pkg::WR_COLLECT;
          end
        end
        default: begin
          wr_state_reg <= ccie_pkg::WR_COLLECT;
        end
      endcase
    end
  end

  assign o_bvalid = (wr_state_reg == ccie_pkg::WR_RESP);
  assign o_bresp  = bresp_reg;

  // ------------------------------------------------------------------
  // write decode
  assign hit_set    = addr_hit(awaddr_reg, ccie_pkg::OFS_EN_SET);
  assign hit_clr    = addr_hit(awaddr_reg, ccie_pkg::OFS_EN_CLR);
  assign hit_flag   = addr_hit(awaddr_reg, ccie_pkg::OFS_FLAG);
  assign hit_status = addr_hit(awaddr_reg, ccie_pkg::OFS_STATUS);
  assign hit_wprot  = addr_hit(awaddr_reg, ccie_pkg::OFS_WPROT);
  assign wr_mapped  = hit_set | hit_clr | hit_flag | hit_status | hit_wprot;
  // locked enable registers refuse writes
  // flag and lock registers stay writable while locked, so software
  // can always clear a flag and release the lock
  assign wr_blocked = lock_reg & (hit_set | hit_clr);

  // only strobed bytes count; upper bits never reach a register
  assign wdata_m = wdata_reg & strb_mask(wstrb_reg);

  // per-source write bits, same layout for set, clear and flag
  always_comb begin
    write_bits = '0;
    write_bits[ccie_pkg::BIT_SUPPLY_MON_SYNC_READY] =
      wdata_m[ccie_pkg::BIT_SUPPLY_MON_SYNC_READY];
    write_bits[ccie_pkg::BIT_SUPPLY_MON_DETECT] =
      wdata_m[ccie_pkg::BIT_SUPPLY_MON_DETECT];
    write_bits[ccie_pkg::BIT_SUPPLY_MON_READY] =
      wdata_m[ccie_pkg::BIT_SUPPLY_MON_READY];
    write_bits[ccie_pkg::BIT_LOOP_REF_CLOCK_STOPPED] =
      wdata_m[ccie_pkg::BIT_LOOP_REF_CLOCK_STOPPED];
    write_bits[ccie_pkg::BIT_LOOP_COARSE_LOCK] =
      wdata_m[ccie_pkg::BIT_LOOP_COARSE_LOCK];
    write_bits[ccie_pkg::BIT_LOOP_FINE_LOCK] =
      wdata_m[ccie_pkg::BIT_LOOP_FINE_LOCK];
    write_bits[ccie_pkg::BIT_LOOP_OUT_OF_BOUNDS] =
      wdata_m[ccie_pkg::BIT_LOOP_OUT_OF_BOUNDS];
    write_bits[ccie_pkg::BIT_LOOP_READY] =
      wdata_m[ccie_pkg::BIT_LOOP_READY];
    write_bits[ccie_pkg::BIT_RC_8MHZ_READY] =
      wdata_m[ccie_pkg::BIT_RC_8MHZ_READY];
    write_bits[ccie_pkg::BIT_RC_32K_READY] =
      wdata_m[ccie_pkg::BIT_RC_32K_READY];
    write_bits[ccie_pkg::BIT_CRYSTAL_32K_READY] =
      wdata_m[ccie_pkg::BIT_CRYSTAL_32K_READY];
    write_bits[ccie_pkg::BIT_CRYSTAL_MAIN_READY] =
      wdata_m[ccie_pkg::BIT_CRYSTAL_MAIN_READY];
  end

  // ------------------------------------------------------------------
  // enable bits: ones set or clear, zeros leave bits alone
  // set and clear share one write port, so they never coincide;
  // a refused write leaves every enable as it was
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enable_reg <= ccie_pkg::EN_RESET;
    end else if (wr_commit & ~wr_blocked & hit_set) begin
      enable_reg <= enable_reg | write_bits;
    end else if (wr_commit & ~wr_blocked & hit_clr) begin
      enable_reg <= enable_reg & ~write_bits;
    end
  end

  // write-protect lock for both enable registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_reg <= ccie_pkg::WPROT_RESET;
    end else if (wr_commit & hit_wprot & wstrb_reg[0]) begin
      lock_reg <= wdata_reg[ccie_pkg::WPROT_LOCK_BIT];
    end
  end

  // write-one-to-clear pulses for the flags
  assign flag_clear = (wr_commit & hit_flag) ? write_bits : '0;

  // ------------------------------------------------------------------
  // status levels cross in and raise flags on their rising edge
  // levels come from other clock domains and may bounce; a flag
  // sees a rise only once the level has settled
  ccie_status_sync #(
    .W       (NUM_SRC)
  ) u_status_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_level (i_clock_status),
    .o_level (status_level),
    .o_rise  (status_rise)
  );

  // sticky flags gated by the enables into one request
  // request is registered, so it trails a flag or enable by one edge
  ccie_irq_flags #(
    .W        (NUM_SRC)
  ) u_irq_flags (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_set    (status_rise),
    .i_clear  (flag_clear),
    .i_enable (enable_reg),
    .o_flag   (flag_value),
    .o_irq    (o_irq)
  );

  assign o_irq_enable = enable_reg;

  // ------------------------------------------------------------------
  // read decode; reserved upper bits read zero
  // the word is sampled at the address handshake, so the answer
  // shows state one cycle before rvalid rises
  always_comb begin
    rd_word = ccie_pkg::SET_REG_RESET;
    rd_resp = ccie_pkg::RESP_OKAY;
    if (addr_hit(i_araddr, ccie_pkg::OFS_EN_SET) |
        addr_hit(i_araddr, ccie_pkg::OFS_EN_CLR)) begin
      rd_word[NUM_SRC-1:0] = enable_reg;
    end else if (addr_hit(i_araddr, ccie_pkg::OFS_FLAG)) begin
      rd_word[NUM_SRC-1:0] = flag_value;
    end else if (addr_hit(i_araddr, ccie_pkg::OFS_STATUS)) begin
      rd_word[NUM_SRC-1:0] = status_level;
    end else if (addr_hit(i_araddr, ccie_pkg::OFS_WPROT)) begin
      rd_word[ccie_pkg::WPROT_LOCK_BIT] = lock_reg;
    end else begin
      rd_resp = ccie_pkg::RESP_SLVERR;
    end
  end

  assign ar_fire   = i_arvalid & o_arready;
  assign o_arready = (rd_state_reg == ccie_pkg::RD_IDLE);

  // read answer one cycle after the address is taken
  // arready drops while an answer waits, so a second read cannot
  // overwrite the read data before the master takes it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_state_reg <= ccie_pkg::RD_IDLE;
      rdata_reg    <= '0;
      rresp_reg    <= ccie_pkg::RESP_OKAY;
    end else begin
      case (rd_state_reg)
        ccie_pkg::RD_IDLE: begin
          if (ar_fire) begin
            rd_state_reg <= ccie_pkg::RD_RESP;
            rdata_reg    <= rd_word;
            rresp_reg    <= rd_resp;
          end
        end
        ccie_pkg::RD_RESP: begin
          if (i_rready) begin
            rd_state_reg <= ccie_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state_reg <= ccie_pkg::RD_IDLE;
        end
      endcase
    end
  end

  assign o_rvalid = (rd_state_reg == ccie_pkg::RD_RESP);
  assign o_rdata  = rdata_reg;
  assign o_rresp  = rresp_reg;

  // protection bits carry no meaning here
  // reduced into one unread net so the inputs still have a reader
  logic prot_unused;
  assign prot_unused = ^{i_awprot, i_arprot};

endmodule // ccie_top

// File: dv/ccie_top_assertions.sv
// port-level checks for the interrupt enable block
`timescale 1ns/100ps
module ccie_top_assertions #(
  parameter int NUM_SRC = 12
) (
  // clock and reset
  input wire logic               i_clk,
  input wire logic               i_rst,
  // register bus
  input wire logic               i_awvalid,
  input wire logic [7:0]         i_awaddr,
  input wire logic               o_awready,
  input wire logic               o_bvalid,
  input wire logic [1:0]         o_bresp,
  input wire logic               i_bready,
  input wire logic               i_arvalid,
  input wire logic [7:0]         i_araddr,
  input wire logic               o_arready,
  input wire logic               o_rvalid,
  input wire logic [31:0]        o_rdata,
  input wire logic [1:0]         o_rresp,
  input wire logic               i_rready,
  // sources and request
  input wire logic [NUM_SRC-1:0] i_clock_status,
  input wire logic               o_irq,
  input wire logic [NUM_SRC-1:0] o_irq_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [7:0] aw_q;
  logic [7:0] ar_q;

  // remember the address of the transfer in flight
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_q <= 8'h00;
      ar_q <= 8'h00;
    end else begin
      if (i_awvalid && o_awready) aw_q <= i_awaddr;
      if (i_arvalid && o_arready) ar_q <= i_araddr;
    end
  end

  a_reset_clean: assert property ($fell(i_rst) |-> o_irq_enable == '0 && !o_irq)
    else $error("enables or request not clear after reset");
  a_enable_on_write: assert property ($changed(o_irq_enable) |->
    $rose(o_bvalid) && o_bresp == ccie_pkg::RESP_OKAY)
    else $error("enables changed without an accepted write");
  a_upper_bits_zero: assert property (o_rvalid && ar_q[7:2] <= 6'h01 |->
    o_rdata[31:12] == 20'h00000 && o_rdata[11:0] == o_irq_enable)
    else $error("enable read shows wrong bits");
  a_irq_needs_en: assert property (o_irq |-> $past(o_irq_enable) != '0)
    else $error("request with no source enabled");
  a_irq_off_disabled: assert property (o_irq_enable == '0 |=> !o_irq)
    else $error("request stays up with all enables clear");
  a_rise_raises: assert property (
    (i_clock_status & ~$past(i_clock_status) & o_irq_enable) != '0 |-> ##[1:10] o_irq)
    else $error("enabled status rise raised no request");
  a_unmapped_wr: assert property (o_bvalid && aw_q[7:2] > 6'h04 |->
    o_bresp == ccie_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  a_unmapped_rd: assert property (o_rvalid && ar_q[7:2] > 6'h04 |->
    o_rresp == ccie_pkg::RESP_SLVERR && o_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  a_bresp_holds: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp))
    else $error("write response dropped before taken");
  a_rdata_holds: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata))
    else $error("read data dropped before taken");
endmodule // ccie_top_assertions

bind ccie_top ccie_top_assertions #(.NUM_SRC(NUM_SRC)) u_ccie_top_assertions (
  .i_clk, .i_rst, .i_awvalid, .i_awaddr, .o_awready, .o_bvalid, .o_bresp, .i_bready,
  .i_arvalid, .i_araddr, .o_arready, .o_rvalid, .o_rdata, .o_rresp, .i_rready,
  .i_clock_status, .o_irq, .o_irq_enable);

// File: dv/test_ccie_top.sv
// self-checking testbench for the interrupt enable block
`timescale 1ns/100ps
module test_ccie_top;
  // design inputs
  logic        i_clk = 1'b0, i_rst = 1'b1;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [2:0]  i_awprot = 3'h0, i_arprot = 3'h0;
  logic [31:0] i_wdata = 32'h00000000;
  logic [3:0]  i_wstrb = 4'hF;
  logic [11:0] i_clock_status = 12'h000;
  // design outputs
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [11:0] o_irq_enable;
  // bench state
  int          miscompares = 0, check_count = 0, cyc = 0;
  logic [11:0] exp;

  ccie_top u_ccie_top (.i_clk, .i_rst, .i_awvalid, .i_awaddr, .i_awprot, .o_awready,
    .i_wvalid, .i_wdata, .i_wstrb, .o_wready, .o_bvalid, .o_bresp, .i_bready,
    .i_arvalid, .i_araddr, .i_arprot, .o_arready, .o_rvalid, .o_rdata, .o_rresp,
    .i_rready, .i_clock_status, .o_irq, .o_irq_enable);

  // 10 MHz clock
  always #50 i_clk = ~i_clk;

  // cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  // verdict and end of run
  task automatic results();
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // compare a data word
  task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch at %0t: word %h expected %h", $time, got, want);
    end
  endtask

  // compare a bus response
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] want);
    check_count++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch at %0t: resp %h expected %h", $time, got, want);
    end
  endtask

  // one write; bready stands with the request until the response is seen
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) begin
        aw_ok = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_ok = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (o_bvalid !== 1'b1);
    chk_resp(o_bresp, er);
    i_bready <= 1'b0;
  endtask

  // one read; rready stands with the request, data taken at the handshake
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (o_rvalid !== 1'b1);
    chk_word(o_rdata, ed);
    chk_resp(o_rresp, er);
    i_rready <= 1'b0;
  endtask

  // drive one status level and let it settle
  task automatic status(input int b, input logic v);
    @(posedge i_clk);
    i_clock_status <= (i_clock_status & ~(12'h001 << b)) | ({11'h000, v} << b);
    repeat (8) @(posedge i_clk);
  endtask

  // set each enable in turn, then zero and reserved writes
  task automatic t_set_bits();
    exp = 12'h000;
    rd_chk(ccie_pkg::OFS_EN_SET, 32'h0, ccie_pkg::RESP_OKAY);
    for (int b = 0; b < 12; b++) begin
      wr_chk(ccie_pkg::OFS_EN_SET, 32'h1 << b, ccie_pkg::RESP_OKAY);
      exp[b] = 1'b1;
      chk_word({20'h0, o_irq_enable}, {20'h0, exp});
    end
    rd_chk(ccie_pkg::OFS_EN_SET, 32'hFFF, ccie_pkg::RESP_OKAY);
    wr_chk(ccie_pkg::OFS_EN_SET, 32'h0, ccie_pkg::RESP_OKAY);
    chk_word({20'h0, o_irq_enable}, 32'hFFF);
    wr_chk(ccie_pkg::OFS_EN_SET, 32'hFFFFF000, ccie_pkg::RESP_OKAY);
    rd_chk(ccie_pkg::OFS_EN_SET, 32'hFFF, ccie_pkg::RESP_OKAY);
  endtask

  // clear each enable in turn through the mirror register
  task automatic t_clear_bits();
    wr_chk(ccie_pkg::OFS_EN_CLR, 32'h0, ccie_pkg::RESP_OKAY);
    chk_word({20'h0, o_irq_enable}, 32'hFFF);
    for (int b = 2; b < 14; b++) begin
      wr_chk(ccie_pkg::OFS_EN_CLR, 32'h1 << (b % 12), ccie_pkg::RESP_OKAY);
      exp[b % 12] = 1'b0;
      chk_word({20'h0, o_irq_enable}, {20'h0, exp});
    end
  endtask

  // each source: gated, raised, cleared, raised again, masked
  task automatic t_sources();
    for (int b = 0; b < 12; b++) begin
      status(b, 1'b1);
      chk_word({31'h0, o_irq}, 32'h0);
      rd_chk(ccie_pkg::OFS_FLAG, 32'h1 << b, ccie_pkg::RESP_OKAY);
      rd_chk(ccie_pkg::OFS_STATUS, 32'h1 << b, ccie_pkg::RESP_OKAY);
      wr_chk(ccie_pkg::OFS_EN_SET, 32'h1 << b, ccie_pkg::RESP_OKAY);
      repeat (2) @(posedge i_clk);
      chk_word({31'h0, o_irq}, 32'h1);
      wr_chk(ccie_pkg::OFS_FLAG, 32'h1 << b, ccie_pkg::RESP_OKAY);
      status(b, 1'b0);
      chk_word({31'h0, o_irq}, 32'h0);
      status(b, 1'b1);
      chk_word({31'h0, o_irq}, 32'h1);
      wr_chk(ccie_pkg::OFS_EN_CLR, 32'h1 << b, ccie_pkg::RESP_OKAY);
      repeat (2) @(posedge i_clk);
      chk_word({31'h0, o_irq}, 32'h0);
      wr_chk(ccie_pkg::OFS_FLAG, 32'h1 << b, ccie_pkg::RESP_OKAY);
      status(b, 1'b0);
    end
  endtask

  // write protection and unmapped places
  task automatic t_refused();
    wr_chk(ccie_pkg::OFS_WPROT, 32'h1, ccie_pkg::RESP_OKAY);
    wr_chk(ccie_pkg::OFS_EN_SET, 32'h1, ccie_pkg::RESP_SLVERR);
    chk_word({20'h0, o_irq_enable}, 32'h0);
    wr_chk(ccie_pkg::OFS_WPROT, 32'h0, ccie_pkg::RESP_OKAY);
    wr_chk(ccie_pkg::OFS_EN_SET, 32'h1, ccie_pkg::RESP_OKAY);
    wr_chk(8'h20, 32'hFFF, ccie_pkg::RESP_SLVERR);
    rd_chk(8'h20, 32'h0, ccie_pkg::RESP_SLVERR);
    chk_word({20'h0, o_irq_enable}, 32'h1);
    i_wstrb <= 4'hE;
    wr_chk(ccie_pkg::OFS_EN_SET, 32'h0000_0202, ccie_pkg::RESP_OKAY);
    i_wstrb <= 4'hF;
    chk_word({20'h0, o_irq_enable}, 32'h201);
    wr_chk(ccie_pkg::OFS_WPROT, 32'h1, ccie_pkg::RESP_OKAY);
    rd_chk(ccie_pkg::OFS_WPROT, 32'h1, ccie_pkg::RESP_OKAY);
    wr_chk(ccie_pkg::OFS_EN_CLR, 32'hFFF, ccie_pkg::RESP_SLVERR);
    chk_word({20'h0, o_irq_enable}, 32'h201);
    wr_chk(ccie_pkg::OFS_WPROT, 32'h0, ccie_pkg::RESP_OKAY);
    wr_chk(ccie_pkg::OFS_STATUS, 32'hFFF, ccie_pkg::RESP_OKAY);
    rd_chk(ccie_pkg::OFS_STATUS, 32'h0, ccie_pkg::RESP_OKAY);
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    chk_word({19'h0, o_irq, o_irq_enable}, 32'h0);
    t_set_bits();
    t_clear_bits();
    t_sources();
    t_refused();
    results();
  end
endmodule // test_ccie_top
